// ==== hw/cto_core.sv ====
// Instruction sequencer for transfer, test-mode and test-against-zero instructions.
`timescale 1ns/1ps
`default_nettype none
module cto_core (
  input  wire logic        MCLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic [7:0]  DATA_I,
  input  wire logic        TEST_MODE_I,
  input  wire logic        NMI_N_I,
  output var  logic [15:0] ADDR_O,
  output var  logic        RW_O,
  output var  logic [15:0] PC_O,
  output var  logic [7:0]  ACC_A_O,
  output var  logic [7:0]  ACC_B_O,
  output var  logic [7:0]  CONDITION_CODE_REGISTER_O,
  output var  logic        ILLEGAL_O,
  output var  logic        SUSPENDED_O
);
  import cto_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and shared state
  // ----------------------------------------------------------------
  logic        tm_s1_q, tm_q, nmi_s1_q, nmi_n_q, nmi_prev_q, nmi_pend_q;
  logic [15:0] pc_q, ea_q;
  logic [15:0] ix_q, iy_q;
  logic [7:0]  acc_a_q, acc_b_q, condition_code_register_q, op_q;
  logic        use_y_q;
  cto_state_t  st_q;
  logic [2:0]  cyc_q;
  cto_flag_if  flg ();

  // The mode strap is synchronised without reset so that it is already valid at the first fetch after reset.
  always_ff @(posedge MCLK_I) begin
    tm_s1_q <= TEST_MODE_I;
    tm_q    <= tm_s1_q;
  end

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      nmi_s1_q <= 1'b1;
      nmi_n_q  <= 1'b1;
    end else begin
      nmi_s1_q <= NMI_N_I;
      nmi_n_q  <= nmi_s1_q;
    end
  end

  // Falling edge of the nonmaskable input is latched until the sequencer takes it.
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      nmi_prev_q <= 1'b1;
      nmi_pend_q <= 1'b0;
    end else begin
      nmi_prev_q <= nmi_n_q;
      if (nmi_prev_q && !nmi_n_q) begin
        nmi_pend_q <= 1'b1;
      end else if (st_q == ST_NMI_HI) begin
        nmi_pend_q <= 1'b0;
      end
    end
  end

  // Index registers are held at reset values; their loading lies outside this unit.
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      ix_q <= 16'h0000;
      iy_q <= 16'h0000;
    end else begin
      ix_q <= ix_q;
      iy_q <= iy_q;
    end
  end

  cto_flag_eval u_flag (.flg(flg));

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic [7:0] operand;
  always_comb begin
    operand = DATA_I;
    if (st_q == ST_FETCH) begin
      operand = 8'h00;
    end else if (op_q == OP_TEST_AGAINST_ZERO_A || op_q == OP_A_TO_B) begin
      operand = acc_a_q;
    end else if (op_q == OP_TEST_AGAINST_ZERO_B || op_q == OP_B_TO_A) begin
      operand = acc_b_q;
    end
  end
  assign flg.value = operand;

  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      st_q      <= ST_FETCH;
      pc_q      <= RESET_PC;
      ea_q      <= 16'h0000;
      op_q      <= 8'h01;
      use_y_q   <= 1'b0;
      cyc_q     <= 3'h1;
      acc_a_q   <= 8'h00;
      acc_b_q   <= 8'h00;
      condition_code_register_q <= RESET_COND_CODES;
      ADDR_O    <= RESET_PC;
      RW_O      <= 1'b1;
      ILLEGAL_O <= 1'b0;
      SUSPENDED_O <= 1'b0;
    end else begin
      ILLEGAL_O <= 1'b0;
      cyc_q     <= cyc_q + 3'h1;
      case (st_q)
        ST_FETCH: begin
          op_q    <= DATA_I;
          use_y_q <= 1'b0;
          cyc_q   <= 3'h2;
          pc_q    <= pc_q + 16'h0001;
          ADDR_O  <= pc_q + 16'h0001;
          case (DATA_I)
            OP_TEST: begin
              if (tm_q) begin
                st_q <= ST_TEST;
              end else begin
                ILLEGAL_O <= 1'b1;
                st_q      <= ST_INH;
              end
            end
            OP_PREFIX_Y: st_q <= ST_PRE;
            OP_TEST_AGAINST_ZERO_EXT: st_q <= ST_HI;
            OP_TEST_AGAINST_ZERO_X:   st_q <= ST_OFF;
            default:     st_q <= ST_INH;
          endcase
        end
        ST_PRE: begin
          op_q    <= DATA_I;
          use_y_q <= 1'b1;
          pc_q    <= pc_q + 16'h0001;
          ADDR_O  <= pc_q + 16'h0001;
          st_q    <= (DATA_I == OP_TEST_AGAINST_ZERO_X) ? ST_OFF : ST_FETCH;
        end
        ST_INH: begin
          // The byte read in this cycle is discarded; the operation completes here.
          case (op_q)
            OP_A_TO_B: begin
              acc_b_q                          <= acc_a_q;
              condition_code_register_q[BIT_N] <= flg.neg;
              condition_code_register_q[BIT_Z] <= flg.zero;
              condition_code_register_q[BIT_V] <= 1'b0;
            end
            OP_B_TO_A: begin
              acc_a_q                          <= acc_b_q;
              condition_code_register_q[BIT_N] <= flg.neg;
              condition_code_register_q[BIT_Z] <= flg.zero;
              condition_code_register_q[BIT_V] <= 1'b0;
            end
            OP_A_TO_CC: begin
              condition_code_register_q        <= acc_a_q;
              condition_code_register_q[BIT_X] <= acc_a_q[BIT_X] & condition_code_register_q[BIT_X];
            end
            OP_CC_TO_A: acc_a_q <= condition_code_register_q;
            OP_TEST_AGAINST_ZERO_A, OP_TEST_AGAINST_ZERO_B: begin
              condition_code_register_q[BIT_N] <= flg.neg;
              condition_code_register_q[BIT_Z] <= flg.zero;
              condition_code_register_q[BIT_V] <= 1'b0;
              condition_code_register_q[BIT_C] <= 1'b0;
            end
            default: ;
          endcase
          ADDR_O <= pc_q;
          st_q   <= ST_FETCH;
          if (nmi_pend_q && !condition_code_register_q[BIT_X]) begin
            st_q <= ST_NMI_HI;
          end
        end
        ST_HI: begin
          ea_q[15:8] <= DATA_I;
          pc_q       <= pc_q + 16'h0001;
          ADDR_O     <= pc_q + 16'h0001;
          st_q       <= ST_LO;
        end
        ST_LO: begin
          pc_q   <= pc_q + 16'h0001;
          ADDR_O <= {ea_q[15:8], DATA_I};
          st_q   <= ST_OPER;
        end
        ST_OFF: begin
          pc_q   <= pc_q + 16'h0001;
          ea_q   <= (use_y_q ? iy_q : ix_q) + {8'h00, DATA_I};
          ADDR_O <= IDLE_ADDR;
          st_q   <= ST_IDLE1;
        end
        ST_IDLE1: begin
          ADDR_O <= ea_q;
          st_q   <= ST_OPER;
        end
        ST_OPER: begin
          condition_code_register_q[BIT_N] <= flg.neg;
          condition_code_register_q[BIT_Z] <= flg.zero;
          condition_code_register_q[BIT_V] <= 1'b0;
          condition_code_register_q[BIT_C] <= 1'b0;
          ADDR_O                           <= IDLE_ADDR;
          st_q                             <= ST_IDLE2;
        end
        ST_IDLE2: begin
          ADDR_O <= IDLE_ADDR;
          st_q   <= ST_IDLE3;
        end
        ST_IDLE3: begin
          ADDR_O <= pc_q;
          st_q   <= ST_FETCH;
        end
        ST_TEST: begin
          // Only reset leaves this state; interrupts are not sampled here.
          pc_q        <= pc_q + 16'h0001;
          ADDR_O      <= pc_q + 16'h0001;
          SUSPENDED_O <= 1'b1;
        end
        ST_NMI_HI: begin
          condition_code_register_q[BIT_X] <= 1'b1;
          condition_code_register_q[BIT_I] <= 1'b1;
          ADDR_O                           <= pc_q;
          st_q                             <= ST_NMI_LO;
        end
        ST_NMI_LO: begin
          ADDR_O <= pc_q;
          st_q   <= ST_FETCH;
        end
        default: st_q <= ST_FETCH;
      endcase
    end
  end

  assign PC_O    = pc_q;
  assign ACC_A_O = acc_a_q;
  assign ACC_B_O = acc_b_q;
  assign CONDITION_CODE_REGISTER_O = condition_code_register_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_ab_copy: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    (st_q == ST_INH && op_q == OP_A_TO_B) |=> (acc_b_q == $past(acc_a_q) && acc_a_q == $past(acc_a_q)))
    else $error("A to B copy wrong");
  a_ab_flags: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    (st_q == ST_INH && op_q == OP_A_TO_B) |=> (condition_code_register_q[BIT_N] == acc_b_q[7]
      && condition_code_register_q[BIT_Z] == (acc_b_q == 8'h00) && !condition_code_register_q[BIT_V]))
    else $error("A to B flags wrong");
  a_x_no_rise: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    (st_q != ST_NMI_HI && !condition_code_register_q[BIT_X]) |=> !condition_code_register_q[BIT_X])
    else $error("mask bit rose without interrupt");
  a_ba_copy: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    (st_q == ST_INH && op_q == OP_B_TO_A) |=> (acc_a_q == $past(acc_b_q) && acc_b_q == $past(acc_b_q)))
    else $error("B to A copy wrong");
  a_test_stuck: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    (st_q == ST_TEST) |=> (st_q == ST_TEST && pc_q == $past(pc_q) + 16'h0001))
    else $error("test opcode left or pc stalled");
  a_test_gate: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    (st_q == ST_FETCH && DATA_I == OP_TEST && !tm_q) |=> (ILLEGAL_O && st_q != ST_TEST))
    else $error("test opcode run outside test mode");
  a_cc_to_a: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    (st_q == ST_FETCH && DATA_I == OP_CC_TO_A) |=> ##1 (st_q == ST_FETCH
      && acc_a_q == condition_code_register_q
      && condition_code_register_q == $past(condition_code_register_q, 2)))
    else $error("flags to A wrong");
  a_zero_test_flags: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    (st_q == ST_OPER) |=> (condition_code_register_q[BIT_N] == $past(DATA_I[7])
      && !condition_code_register_q[BIT_V] && !condition_code_register_q[BIT_C]))
    else $error("test flags wrong");
  a_ext_len: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    (st_q == ST_FETCH && DATA_I == OP_TEST_AGAINST_ZERO_EXT) |=> ##5 (st_q == ST_FETCH))
    else $error("extended test length wrong");
  a_cycle_count: assert property (@(posedge MCLK_I) disable iff (!RESET_N_I)
    (st_q == ST_INH || st_q == ST_IDLE3)
      |-> (cyc_q == ((st_q == ST_INH) ? CYC_INH : (use_y_q ? CYC_IDX_Y : CYC_EXT))))
    else $error("instruction cycle count wrong");
endmodule : cto_core
`default_nettype wire

// ==== hw/cto_flag_eval.sv ====
// Flag evaluator for the sign and zero of an eight-bit value.
`timescale 1ns/1ps
`default_nettype none
module cto_flag_eval (
  cto_flag_if.unit flg
);
  assign flg.neg  = flg.value[7];
  assign flg.zero = (flg.value == 8'h00);
endmodule : cto_flag_eval
`default_nettype wire

// ==== include/cto_flag_if.sv ====
// Interface carrying operand and computed N and Z flags between the core and its flag unit.
`timescale 1ns/1ps
`default_nettype none
interface cto_flag_if;
  logic [7:0] value;
  logic       neg;
  logic       zero;
  modport core (output value, input neg, zero);
  modport unit (input value, output neg, zero);
endinterface : cto_flag_if
`default_nettype wire

// ==== include/cto_pkg.sv ====
// Package of constants and types for the transfer and test instruction unit.
package cto_pkg;
  localparam logic [7:0]  OP_TEST     = 8'h00;
  localparam logic [7:0]  OP_A_TO_CC  = 8'h06;
  localparam logic [7:0]  OP_CC_TO_A  = 8'h07;
  localparam logic [7:0]  OP_A_TO_B   = 8'h16;
  localparam logic [7:0]  OP_B_TO_A   = 8'h17;
  localparam logic [7:0]  OP_PREFIX_Y = 8'h18;
  localparam logic [7:0]  OP_TEST_AGAINST_ZERO_A   = 8'h4d;
  localparam logic [7:0]  OP_TEST_AGAINST_ZERO_B   = 8'h5d;
  localparam logic [7:0]  OP_TEST_AGAINST_ZERO_X   = 8'h6d;
  localparam logic [7:0]  OP_TEST_AGAINST_ZERO_EXT = 8'h7d;
  localparam logic [15:0] IDLE_ADDR   = 16'hffff;
  localparam logic [15:0] RESET_PC    = 16'h0000;
  localparam logic [7:0]  RESET_COND_CODES = 8'hd0;
  localparam int          BIT_S = 7;
  localparam int          BIT_X = 6;
  localparam int          BIT_I = 4;
  localparam int          BIT_N = 3;
  localparam int          BIT_Z = 2;
  localparam int          BIT_V = 1;
  localparam int          BIT_C = 0;
  localparam logic [2:0]  CYC_INH     = 3'h2;
  localparam logic [2:0]  CYC_EXT     = 3'h6;
  localparam logic [2:0]  CYC_IDX_Y   = 3'h7;
  typedef enum logic [3:0] {
    ST_FETCH, ST_INH, ST_PRE, ST_HI, ST_LO, ST_OFF, ST_IDLE1, ST_OPER, ST_IDLE2, ST_IDLE3,
    ST_TEST, ST_NMI_HI, ST_NMI_LO
  } cto_state_t;
endpackage : cto_pkg

// ==== verification/cto_mem_model.sv ====
// Memory model that answers the core's read cycles.
`timescale 1ns/1ps
`default_nettype none
module cto_mem_model (
  input  wire logic [15:0] addr_i,
  output var  logic [7:0]  data_o
);
  logic [7:0] mem [0:65535];

  always_comb data_o = mem[addr_i];

  // Unloaded locations hold their low address byte XOR 5a, repeating every 256 addresses, so a stale byte is never trusted.
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
  end
endmodule : cto_mem_model
`default_nettype wire

// ==== verification/tb_cpu_transfer_test_ops.sv ====
// Self-checking testbench for the transfer and test instruction unit.
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_transfer_test_ops;
  import cto_pkg::*;
  logic        mclk        = 1'b0;
  logic        rst_n       = 1'b0;
  logic        test_mode   = 1'b0;
  logic        nmi_n       = 1'b1;
  logic [7:0]  data;
  logic [15:0] addr;
  logic [15:0] pc;
  logic [7:0]  acc_a;
  logic [7:0]  acc_b;
  logic [7:0]  condition_code_register;
  logic        rw;
  logic        illegal;
  logic        suspended;
  int          errors      = 0;
  int          checks      = 0;
  int          illegal_cnt = 0;

  always #5 mclk = ~mclk;

  cto_core cto_core_inst (.MCLK_I(mclk), .RESET_N_I(rst_n), .DATA_I(data), .TEST_MODE_I(test_mode),
    .NMI_N_I(nmi_n), .ADDR_O(addr), .RW_O(rw), .PC_O(pc), .ACC_A_O(acc_a), .ACC_B_O(acc_b),
    .CONDITION_CODE_REGISTER_O(condition_code_register), .ILLEGAL_O(illegal), .SUSPENDED_O(suspended));
  cto_mem_model cto_mem_model_inst (.addr_i(addr), .data_o(data));

  always @(posedge mclk) if (illegal === 1'b1) illegal_cnt++;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk16

  task automatic chk_regs(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    chk16("acc_a", {8'h00, a}, {8'h00, acc_a});
    chk16("acc_b", {8'h00, b}, {8'h00, acc_b});
    chk16("condition_code_register", {8'h00, c}, {8'h00, condition_code_register});
  endtask : chk_regs

  // Follows one instruction's bus cycles, then checks the registers at the next fetch.
  task automatic run_op(input logic [15:0] seq [$], input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    foreach (seq[i]) begin
      chk16("addr", seq[i], addr);
      chk16("rw", 16'h0001, {15'h0000, rw});
      @(posedge mclk);
      #1;
    end
    chk_regs(a, b, c);
  endtask : run_op

  task automatic do_reset(input logic tm);
    @(posedge mclk);
    rst_n     <= 1'b0;
    test_mode <= tm;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
  endtask : do_reset

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_copy_first;
    run_op('{16'h0000, 16'h0001}, 8'hd0, 8'h00, 8'hd0);
    run_op('{16'h0001, 16'h0002}, 8'hd0, 8'hd0, 8'hd8);
  endtask : t_copy_first

  task automatic t_test_zero;
    run_op('{16'h0002, 16'h0003, 16'h0004, 16'h0040, 16'hffff, 16'hffff}, 8'hd0, 8'hd0, 8'hd4);
    run_op('{16'h0005, 16'h0006}, 8'hd0, 8'hd0, 8'hd8);
    run_op('{16'h0006, 16'h0007, 16'hffff, 16'h0030, 16'hffff, 16'hffff}, 8'hd0, 8'hd0, 8'hd4);
    run_op('{16'h0008, 16'h0009}, 8'hd0, 8'hd0, 8'hd8);
    run_op('{16'h0009, 16'h000a, 16'h000b, 16'hffff, 16'h0031, 16'hffff, 16'hffff}, 8'hd0, 8'hd0, 8'hd4);
  endtask : t_test_zero

  task automatic t_copy_back;
    run_op('{16'h000c, 16'h000d}, 8'hd4, 8'hd0, 8'hd4);
    run_op('{16'h000d, 16'h000e}, 8'hd4, 8'hd0, 8'hd8);
    run_op('{16'h000e, 16'h000f}, 8'hd4, 8'hd0, 8'hd4);
    run_op('{16'h000f, 16'h0010}, 8'hd0, 8'hd0, 8'hd8);
  endtask : t_copy_back

  task automatic t_illegal;
    run_op('{16'h0010, 16'h0011}, 8'hd0, 8'hd0, 8'hd8);
    repeat (2) @(posedge mclk);
    #1;
    chk16("illegal pulses", 16'h0001, 16'(illegal_cnt));
    chk16("suspended", 16'h0000, {15'h0000, suspended});
  endtask : t_illegal

  task automatic t_test_mode;
    cto_mem_model_inst.mem[0] = 8'h00;
    do_reset(1'b1);
    run_op('{16'h0000, 16'h0001, 16'h0002, 16'h0003}, 8'h00, 8'h00, 8'hd0);
    for (int i = 0; i < 40; i++) begin
      chk16("addr", 16'h0004 + 16'(i), addr);
      chk16("pc", 16'h0004 + 16'(i), pc);
      chk16("suspended", 16'h0001, {15'h0000, suspended});
      @(posedge mclk);
      nmi_n <= (i != 10);
      #1;
    end
    chk_regs(8'h00, 8'h00, 8'hd0);
    chk16("illegal pulses", 16'h0001, 16'(illegal_cnt));
    @(posedge mclk);
    rst_n <= 1'b0;
    @(posedge mclk);
    #1;
    chk16("suspended", 16'h0000, {15'h0000, suspended});
  endtask : t_test_mode

  // Clears the mask bit from a zero accumulator, then lets a pending nonmaskable interrupt be taken.
  task automatic t_mask_clear;
    cto_mem_model_inst.mem[0] = 8'h06;
    @(posedge mclk);
    nmi_n <= 1'b0;
    do_reset(1'b0);
    run_op('{16'h0000, 16'h0001}, 8'h00, 8'h00, 8'h00);
    run_op('{16'h0001, 16'h0002, 16'h0002, 16'h0002}, 8'h00, 8'h00, 8'h54);
    @(posedge mclk);
    nmi_n <= 1'b1;
  endtask : t_mask_clear

  task automatic test_done;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  initial begin
    logic [7:0] prog [17] = '{8'h07, 8'h16, 8'h7d, 8'h00, 8'h40, 8'h4d, 8'h6d, 8'h30, 8'h5d,
                              8'h18, 8'h6d, 8'h31, 8'h07, 8'h5d, 8'h06, 8'h17, 8'h00};
    #1;
    foreach (prog[i]) cto_mem_model_inst.mem[i] = prog[i];
    cto_mem_model_inst.mem[16'h0030] = 8'h00;
    cto_mem_model_inst.mem[16'h0031] = 8'h00;
    cto_mem_model_inst.mem[16'h0040] = 8'h00;
    do_reset(1'b0);
    t_copy_first();
    t_test_zero();
    t_copy_back();
    t_illegal();
    t_test_mode();
    t_mask_clear();
    test_done();
  end

  initial begin
    #50000;
    errors++;
    test_done();
  end
endmodule : tb_cpu_transfer_test_ops
`default_nettype wire
